// [src/ecc_cfg.svh]
// Purpose: Constants for the encoder counter control block
// Assumes: 100 MHz system clock, APB byte addresses
// Notes:   Shared by the package and the design module
`ifndef ECC_CFG_SVH
`define ECC_CFG_SVH
// Register byte offsets
`define ECC_STAT_OFS 12'h068
`define ECC_CTRL_OFS 12'h06C
`define ECC_CNT0_OFS 12'h070
`define ECC_CNT1_OFS 12'h074
`define ECC_CNT2_OFS 12'h078
`define ECC_CNT3_OFS 12'h07C
`define ECC_CTRL_RST 32'h00000000
// Per-channel slice layout in the control word
`define ECC_CH_STRIDE 8
`define ECC_MODE_LSB 0
`define ECC_GATE_LSB 2
`define ECC_RST_LSB 4
`define ECC_FILT_BIT 7
// Input positions inside a channel's group of three
`define ECC_A_SEL 0
`define ECC_B_SEL 1
`define ECC_I_SEL 2
// Counting modes
`define ECC_MODE_QUAD 2'h0
`define ECC_MODE_RISE 2'h1
`define ECC_MODE_FALL 2'h2
`define ECC_MODE_BOTH 2'h3
// Count gating codes
`define ECC_GATE_ON 2'h0
`define ECC_GATE_OFF 2'h1
`define ECC_GATE_IDXLO 2'h2
`define ECC_GATE_IDXHI 2'h3
// Reset source codes
`define ECC_RST_NONE 3'h0
`define ECC_RST_HOLD 3'h1
`define ECC_RST_LVLLO 3'h2
`define ECC_RST_LVLHI 3'h3
`define ECC_RST_RISE 3'h4
`define ECC_RST_FALL 3'h5
`define ECC_RST_EDGE 3'h6
// Noise filter timing
`define ECC_CLK_NS 10
`define ECC_FILT_NS 320
`define ECC_FILT_CYC ((`ECC_FILT_NS + `ECC_CLK_NS - 1) / `ECC_CLK_NS)
`define ECC_FCNT_W 6
`endif

// [src/ecc_pkg.sv]
// Purpose: Types for the encoder counter control block
// Assumes: Constants come from ecc_cfg.svh
// Notes:   Whole module state is one packed struct
`include "ecc_cfg.svh"
package ecc_pkg;
  // Complete register state of the block
  typedef struct packed {
    logic [11:0]                  meta;
    logic [11:0]                  sync;
    logic [11:0][`ECC_FCNT_W-1:0] fcnt;
    logic [11:0]                  flt;
    logic [11:0]                  prev;
    logic [31:0]                  ctrl;
    logic [3:0][31:0]             cnt;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
  } ecc_state_t;
endpackage : ecc_pkg

// [src/ecc_encoder_control.sv]
// Purpose: Four-channel incremental encoder counter with shared control
// Assumes: APB slave, one wait state per access
// Notes:   Encoder pins are asynchronous and are double-synchronised
`timescale 1ns/1ps
`include "ecc_cfg.svh"

module ecc_encoder_control (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Encoder pins, one bit per channel
  input  wire logic [3:0]  ENC_A_I,
  input  wire logic [3:0]  ENC_B_I,
  input  wire logic [3:0]  ENC_I_I
);

  // Gating decode, shared by every channel
  function automatic logic gate_open(
    input logic [1:0] code,
    input logic       idx
  );
    logic ok;
    ok = 1'b0;
    case (code)
      `ECC_GATE_ON:    ok = 1'b1;
      `ECC_GATE_OFF:   ok = 1'b0;
      `ECC_GATE_IDXLO: ok = ~idx;
      `ECC_GATE_IDXHI: ok = idx;
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction : gate_open

  // Reset source decode; reserved code clears nothing
  function automatic logic clear_now(
    input logic [2:0] code,
    input logic       idx,
    input logic       idx_prev
  );
    logic clr;
    clr = 1'b0;
    case (code)
      `ECC_RST_NONE:  clr = 1'b0;
      `ECC_RST_HOLD:  clr = 1'b1;
      `ECC_RST_LVLLO: clr = ~idx;
      `ECC_RST_LVLHI: clr = idx;
      `ECC_RST_RISE:  clr = idx & ~idx_prev;
      `ECC_RST_FALL:  clr = ~idx & idx_prev;
      `ECC_RST_EDGE:  clr = idx ^ idx_prev;
      default:        clr = 1'b0;
    endcase
    return clr;
  endfunction : clear_now

  // Step and direction decode, returns {step, up}
  function automatic logic [1:0] step_dir(
    input logic [1:0] mode,
    input logic       a,
    input logic       b,
    input logic       pa,
    input logic       pb
  );
    logic st;
    logic up;
    st = 1'b0;
    up = 1'b0;
    case (mode)
      `ECC_MODE_QUAD: begin
        // A lone transition on A or B is one step; both at
        // once is a phase error and is not counted
        st = (a ^ pa) ^ (b ^ pb);
        up = a ^ pb;
      end
      `ECC_MODE_RISE: begin
        st = a & ~pa;
        up = b;
      end
      `ECC_MODE_FALL: begin
        st = ~a & pa;
        up = b;
      end
      `ECC_MODE_BOTH: begin
        st = a ^ pa;
        up = b;
      end
      default: begin
        st = 1'b0;
        up = 1'b0;
      end
    endcase
    return {st, up};
  endfunction : step_dir

  // State of the whole block
  ecc_pkg::ecc_state_t st_reg;
  ecc_pkg::ecc_state_t st_next;

  // Per-input and per-channel results of the generate loop
  logic [11:0]            raw_pins;
  logic [`ECC_FCNT_W-1:0] fcnt_next [12];
  logic                   flt_next  [12];
  logic                   lvl       [12];
  logic [31:0]            cnt_next  [4];

  // APB phase decode
  logic acc_first;
  logic acc_last;
  logic [31:0] rd_data;
  logic        rd_hit;

  // Last filter count before the filtered level may follow
  localparam logic [`ECC_FCNT_W-1:0] FCNT_LAST =
    `ECC_FCNT_W'(`ECC_FILT_CYC - 1);

  // One slice per channel: pins, filters, decode, counter
  for (genvar c = 0; c < 4; c++) begin : g_ch
    localparam int BASE = c * `ECC_CH_STRIDE;
    localparam int K0   = 3 * c;

    logic [1:0] mode;
    logic [1:0] gate;
    logic [2:0] rsrc;
    logic       filt_en;
    logic       a;
    logic       b;
    logic       idx;
    logic       pa;
    logic       pb;
    logic       pidx;
    logic [1:0] sd;
    logic       clr;
    logic       go;

    // Pin grouping: A, B, index
    assign raw_pins[K0 + `ECC_A_SEL] = ENC_A_I[c];
    assign raw_pins[K0 + `ECC_B_SEL] = ENC_B_I[c];
    assign raw_pins[K0 + `ECC_I_SEL] = ENC_I_I[c];

    // Field slices, identical layout for every channel
    assign mode    = st_reg.ctrl[BASE + `ECC_MODE_LSB +: 2];
    assign gate    = st_reg.ctrl[BASE + `ECC_GATE_LSB +: 2];
    assign rsrc    = st_reg.ctrl[BASE + `ECC_RST_LSB +: 3];
    assign filt_en = st_reg.ctrl[BASE + `ECC_FILT_BIT];

    // Stability filter per input; it keeps running while
    // bypassed so enabling it shows no stale level once the input has held for 32 cycles
    for (genvar j = 0; j < 3; j++) begin : g_in
      localparam int K = K0 + j;
      logic same;
      logic done;
      assign same = st_reg.sync[K] == st_reg.flt[K];
      assign done = st_reg.fcnt[K] == FCNT_LAST;
      assign fcnt_next[K] = (same | done) ?
        '0 : st_reg.fcnt[K] + 1'b1;
      assign flt_next[K] = (~same & done) ?
        st_reg.sync[K] : st_reg.flt[K];
      assign lvl[K] = filt_en ?
        st_reg.flt[K] : st_reg.sync[K];
    end

    // Current and previous levels after the filter choice
    assign a    = lvl[K0 + `ECC_A_SEL];
    assign b    = lvl[K0 + `ECC_B_SEL];
    assign idx  = lvl[K0 + `ECC_I_SEL];
    assign pa   = st_reg.prev[K0 + `ECC_A_SEL];
    assign pb   = st_reg.prev[K0 + `ECC_B_SEL];
    assign pidx = st_reg.prev[K0 + `ECC_I_SEL];

    // Decode of the three settings
    assign sd  = step_dir(mode, a, b, pa, pb);
    assign clr = clear_now(rsrc, idx, pidx);
    assign go  = gate_open(gate, idx) & sd[1];

    // Clear wins over counting; value wraps both ways
    always_comb begin
      if (clr) begin
        cnt_next[c] = '0;
      end else if (go && sd[0]) begin
        cnt_next[c] = st_reg.cnt[c] + 32'h1;
      end else if (go) begin
        cnt_next[c] = st_reg.cnt[c] - 32'h1;
      end else begin
        cnt_next[c] = st_reg.cnt[c];
      end
    end
  end

  // APB: first access cycle loads the answer, second ends it
  assign acc_first = PSEL_I & PENABLE_I & ~st_reg.pready;
  assign acc_last  = PSEL_I & PENABLE_I & st_reg.pready;

  // Read mux; status shows index levels after the filter choice
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    case (PADDR_I[11:2])
      10'(`ECC_STAT_OFS >> 2): begin
        for (int c = 0; c < 4; c++) begin
          rd_data[c * `ECC_CH_STRIDE] = lvl[3 * c + `ECC_I_SEL];
        end
      end
      10'(`ECC_CTRL_OFS >> 2): rd_data = st_reg.ctrl;
      10'(`ECC_CNT0_OFS >> 2): rd_data = st_reg.cnt[0];
      10'(`ECC_CNT1_OFS >> 2): rd_data = st_reg.cnt[1];
      10'(`ECC_CNT2_OFS >> 2): rd_data = st_reg.cnt[2];
      10'(`ECC_CNT3_OFS >> 2): rd_data = st_reg.cnt[3];
      default:                 rd_hit  = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;

    // Two-stage synchroniser; stage one feeds stage two only
    st_next.meta = raw_pins;
    st_next.sync = st_reg.meta;

    // Filters and edge history
    for (int k = 0; k < 12; k++) begin
      st_next.fcnt[k] = fcnt_next[k];
      st_next.flt[k]  = flt_next[k];
      st_next.prev[k] = lvl[k];
    end

    // Counters
    for (int c = 0; c < 4; c++) begin
      st_next.cnt[c] = cnt_next[c];
    end

    // Bus answer: valid for the single completing cycle
    st_next.pready  = acc_first;
    st_next.prdata  = '0;
    st_next.pslverr = 1'b0;
    if (acc_first) begin
      st_next.pslverr = ~rd_hit;
      if (!PWRITE_I) begin
        st_next.prdata = rd_data;
      end
    end

    // Control write lands on the completing edge only
    if (acc_last && PWRITE_I &&
        PADDR_I[11:2] == 10'(`ECC_CTRL_OFS >> 2)) begin
      for (int n = 0; n < 4; n++) begin
        if (PSTRB_I[n]) begin
          st_next.ctrl[n * 8 +: 8] = PWDATA_I[n * 8 +: 8];
        end
      end
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_reg      <= '0;
      st_reg.ctrl <= `ECC_CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign PRDATA_O  = st_reg.prdata;
  assign PREADY_O  = st_reg.pready;
  assign PSLVERR_O = st_reg.pslverr;

endmodule : ecc_encoder_control

// [dv/ecc_encoder_control_props.sv]
// Purpose: APB answer checks for the encoder control block
// Assumes: full byte strobes on every write
// Notes:   shadow_reg mirrors the control word
`timescale 1ns/1ps
`include "ecc_cfg.svh"
module ecc_encoder_control_props (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [3:0]  ENC_A_I,
  input wire logic [3:0]  ENC_B_I,
  input wire logic [3:0]  ENC_I_I
);
  logic [31:0] shadow_reg;
  logic        acc;
  logic        ctl;
  logic        map;
  // Address decode of the mapped window
  assign acc = PSEL_I && PENABLE_I;
  assign ctl = PADDR_I[11:2] == 10'(`ECC_CTRL_OFS >> 2);
  assign map = PADDR_I[11:2] >= 10'(`ECC_STAT_OFS >> 2) && PADDR_I[11:2] <= 10'(`ECC_CNT3_OFS >> 2);
  // Expected control word, updated only on a completing write
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) shadow_reg <= 32'h0;
    else if (acc && PREADY_O && PWRITE_I && ctl) shadow_reg <= PWDATA_I;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_one_wait; acc && !PREADY_O |=> PREADY_O; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_cause; PREADY_O |-> acc && $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_idle; !PREADY_O |-> PRDATA_O == 32'h0 && !PSLVERR_O; endproperty
  a_idle: assert property (p_idle) else $error("outputs not quiet");
  property p_ctl_rd; PREADY_O && ctl && !PWRITE_I |-> PRDATA_O == shadow_reg; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
  property p_unmap; PREADY_O && !map |-> PSLVERR_O && PRDATA_O == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map; PREADY_O && map |-> !PSLVERR_O; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  c_wr_ctl: cover property (acc && PREADY_O && PWRITE_I && ctl);
  c_rd_ctl: cover property (acc && PREADY_O && !PWRITE_I && ctl);
  c_err: cover property (PSLVERR_O);
endmodule : ecc_encoder_control_props
bind ecc_encoder_control ecc_encoder_control_props i_ecc_encoder_control_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .ENC_A_I(ENC_A_I), .ENC_B_I(ENC_B_I), .ENC_I_I(ENC_I_I));

// [dv/ecc_enc_model.sv]
// Purpose: Four quadrature encoders with index
// Assumes: one step request per clock per channel
// Notes:   pulse width is set by request spacing
`timescale 1ns/1ps
module ecc_enc_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] fwd_i,
  input  wire logic [3:0] back_i,
  input  wire logic [3:0] idx_i,
  output logic      [3:0] a_o,
  output logic      [3:0] b_o,
  output logic      [3:0] i_o
);
  logic [3:0][1:0] ph = '0;
  // Gray walk, one pin per step so no double change
  always @(posedge clk_i) begin
    for (int n = 0; n < 4; n++) ph[n] <= ph[n] + 2'(fwd_i[n]) - 2'(back_i[n]);
  end
  // A leads B when walking forward
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      a_o[n] = ph[n] == 2'h1 || ph[n] == 2'h2;
      b_o[n] = ph[n][1];
    end
  end
  assign i_o = idx_i;
endmodule : ecc_enc_model

// [dv/ecc_encoder_control_test.sv]
// Purpose: Self-checking bench for the encoder control block
// Assumes: encoder model drives the pins
// Notes:   expected counts are kept per channel
`timescale 1ns/1ps
`include "ecc_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ecc_encoder_control_test;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            pen = 1'b0;
  logic            pwr = 1'b0;
  logic [11:0]     padr = '0;
  logic [31:0]     pwd = '0;
  logic [31:0]     prd;
  logic [31:0]     rd;
  logic            prdy;
  logic            perr;
  logic            er;
  logic            hold;
  logic [3:0]      a;
  logic [3:0]      b;
  logic [3:0]      ix;
  logic [3:0]      msk;
  logic [3:0]      idx = '0;
  logic [3:0]      fwd = '0;
  logic [3:0]      back = '0;
  logic [3:0][1:0] ph = '0;
  logic [3:0][1:0] mode = '0;
  logic [3:0][31:0] xc = '0;
  int              error_cnt = 0;
  int              compares = 0;
  int              k;
  ecc_encoder_control i_ecc_encoder_control (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(4'hF),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .ENC_A_I(a), .ENC_B_I(b), .ENC_I_I(ix));
  ecc_enc_model i_ecc_enc_model (.clk_i(clk), .fwd_i(fwd), .back_i(back), .idx_i(idx),
    .a_o(a), .b_o(b), .i_o(ix));
  always #5 clk = ~clk;
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // Expected count change of one model step
  function automatic logic [31:0] dlt(input logic [1:0] m, p, q);
    logic a0;
    logic a1;
    a0 = p == 2'h1 || p == 2'h2;
    a1 = q == 2'h1 || q == 2'h2;
    if (m == 2'h0) return (a1 ^ p[1]) ? 32'h1 : 32'hFFFFFFFF;
    if (a0 == a1 || (m == 2'h1 && !a1) || (m == 2'h2 && a1)) return 32'h0;
    return q[1] ? 32'h1 : 32'hFFFFFFFF;
  endfunction : dlt
  // Request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= ad;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) error_cnt++;
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wctl(input logic [31:0] v);
    apb(1'b1, `ECC_CTRL_OFS, v);
    apb(1'b0, `ECC_CTRL_OFS, 32'h0);
    `CHK(rd, v)
    for (int n = 0; n < 4; n++) mode[n] = v[8*n+:2];
  endtask : wctl
  task automatic cnts(input int w);
    repeat (w) @(posedge clk);
    for (int n = 0; n < 4; n++) begin
      apb(1'b0, `ECC_CNT0_OFS + 12'(4 * n), 32'h0);
      `CHK(rd, xc[n])
    end
  endtask : cnts
  task automatic step(input logic [3:0] up, m, input logic on, input int gap);
    logic [1:0] q;
    fwd <= up & m;
    back <= ~up & m;
    @(posedge clk);
    fwd <= 4'h0;
    back <= 4'h0;
    for (int n = 0; n < 4; n++) begin
      q = up[n] ? ph[n] + 2'h1 : ph[n] - 2'h1;
      if (on && m[n]) xc[n] += dlt(mode[n], ph[n], q);
      if (m[n]) ph[n] = q;
    end
    repeat (gap) @(posedge clk);
  endtask : step
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    k = $urandom(32'h97C5E54F);
    apb(1'b0, `ECC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    cnts(1);
    apb(1'b0, 12'h100, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    repeat (12) begin
      wctl($urandom & 32'h03030303);
      repeat ($urandom_range(12, 3)) step(4'($urandom), 4'hF, 1'b1, 2);
      cnts(8);
    end
    // Gating against index level
    for (int g = 0; g < 8; g++) begin
      idx <= {4{g[2]}};
      wctl({4{4'h0, g[1:0], 2'h0}});
      repeat (4) step(4'($urandom), 4'hF, g[1:0] == 2'h0 || g[1:0] == {1'b1, g[2]}, 2);
      cnts(8);
      // Status shows the index level of every channel
      apb(1'b0, `ECC_STAT_OFS, 32'h0);
      `CHK(rd, {4{7'h0, g[2]}})
    end
    // Clear sources: idle low, rise, fall
    for (int c = 0; c < 8; c++) begin
      idx <= 4'h0;
      wctl(32'h0);
      repeat (3) step(4'hF, 4'hF, 1'b1, 2);
      wctl({4{1'b0, c[2:0], 4'h0}});
      for (int s = 0; s < 3; s++) begin
        if (s > 0) idx <= {4{s == 1}};
        repeat (6) @(posedge clk);
        hold = c == 1 || (c == 2 && s != 1) || (c == 3 && s == 1);
        if (hold || (s > 0 && (c == 6 || c == 3 + s))) xc = '0;
        repeat (2) step(4'hF, 4'hF, !hold, 2);
        cnts(8);
      end
    end
    // Park at phase 0 with counting off, then glitch A
    wctl(32'h04040404);
    repeat (3) begin
      for (int n = 0; n < 4; n++) msk[n] = ph[n] != 2'h0;
      step(4'hF, msk, 1'b0, 2);
    end
    // Let the filters settle so enabling them makes no false edge
    repeat (40) @(posedge clk);
    wctl(32'h81818181);
    step(4'hF, 4'hF, 1'b0, 30);
    step(4'h0, 4'hF, 1'b0, 40);
    cnts(8);
    step(4'hF, 4'hF, 1'b1, 33);
    step(4'h0, 4'hF, 1'b1, 40);
    cnts(8);
    wctl(32'h01010101);
    step(4'hF, 4'hF, 1'b1, 3);
    step(4'h0, 4'hF, 1'b1, 3);
    cnts(8);
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule : ecc_encoder_control_test
